// file: logic/input_reading_math_params.svh
// Constants for the per-input reading math block.
// Assumes readings are signed fixed point words of a common width.
`ifndef INPUT_READING_MATH_PARAMS_SVH
`define INPUT_READING_MATH_PARAMS_SVH
`define IRM_DATA_W          32
`define IRM_FRAC_W          16
`define IRM_FILT_PTS_MIN    7'd2
`define IRM_FILT_PTS_MAX    7'd64
`define IRM_FILT_PTS_RST    7'd8
`define IRM_WIN_PCT_MIN     4'd1
`define IRM_WIN_PCT_MAX     4'd10
`define IRM_WIN_PCT_RST     4'd1
`define IRM_GAIN_RST        32'h00010000
`define IRM_PCT_DIV         100
`endif

// file: logic/input_reading_math_pkg.sv
// Types for the per-input reading math block.
// Assumes the constants header is compiled alongside.
package input_reading_math_pkg;
   typedef enum logic [1:0] {src_kelvin, src_celsius, src_sensor, src_linear} mm_src_t;
   typedef enum logic [1:0] {x_sensor, x_kelvin, x_celsius} x_src_t;
   typedef enum logic [2:0] {b_number, b_plus_one, b_minus_one, b_plus_two, b_minus_two} b_src_t;
   typedef enum logic {eq_mx_plus_b, eq_m_x_plus_b} eq_form_t;
endpackage

// file: logic/input_reading_math.sv
// Reading post-processor for two sensor inputs: filter, linear equation, max/min.
// Assumes readings arrive on the instrument clock with a one-cycle valid strobe per input.
`timescale 1ns/1ps
`include "input_reading_math_params.svh"

module input_reading_math
#(
   parameter int DATA_W = `IRM_DATA_W,
   parameter int FRAC_W = `IRM_FRAC_W
)
(
   // Clock and reset
   input  wire logic                                i_clock,
   input  wire logic                                i_rst,
   // Readings, one lane per input
   input  wire logic [1:0]                          i_valid,
   input  wire logic [1:0][DATA_W-1:0]              i_kelvin,
   input  wire logic [1:0][DATA_W-1:0]              i_celsius,
   input  wire logic [1:0][DATA_W-1:0]              i_sensor,
   input  wire logic [1:0][DATA_W-1:0]              i_full_scale,
   // Setpoints of the two loops
   input  wire logic [DATA_W-1:0]                   i_loop_one_setpoint,
   input  wire logic [DATA_W-1:0]                   i_loop_two_setpoint,
   // Per-input configuration
   input  wire input_reading_math_pkg::mm_src_t     i_mm_src [2],
   input  wire input_reading_math_pkg::x_src_t      i_x_src [2],
   input  wire input_reading_math_pkg::b_src_t      i_b_src [2],
   input  wire input_reading_math_pkg::eq_form_t    i_eq_form [2],
   input  wire logic [1:0][DATA_W-1:0]              i_gain,
   input  wire logic [1:0][DATA_W-1:0]              i_offset,
   input  wire logic [1:0]                          i_filt_en,
   input  wire logic [1:0][6:0]                     i_filt_pts,
   input  wire logic [1:0][3:0]                     i_filt_win_pct,
   input  wire logic [1:0]                          i_param_change,
   input  wire logic [1:0]                          i_math_reset,
   // Results
   output logic [1:0]                               o_valid,
   output logic [1:0][DATA_W-1:0]                   o_kelvin,
   output logic [1:0][DATA_W-1:0]                   o_celsius,
   output logic [1:0][DATA_W-1:0]                   o_sensor,
   output logic [1:0][DATA_W-1:0]                   o_linear,
   output logic [1:0][DATA_W-1:0]                   o_max,
   output logic [1:0][DATA_W-1:0]                   o_min,
   output logic [1:0]                               o_mm_valid,
   output logic [1:0][DATA_W-1:0]                   o_loop_kelvin,
   output logic [1:0][DATA_W-1:0]                   o_loop_celsius,
   output logic [1:0][DATA_W-1:0]                   o_loop_sensor
);
   import input_reading_math_pkg::*;

   initial
   begin
      if (DATA_W < 8 || FRAC_W < 1 || FRAC_W >= DATA_W)
         $error("input_reading_math: unusable DATA_W or FRAC_W");
      if (`IRM_FILT_PTS_MIN == 7'd0 || `IRM_FILT_PTS_MIN > `IRM_FILT_PTS_MAX)
         $error("input_reading_math: point count span cannot be served");
      if (`IRM_WIN_PCT_MIN == 4'd0 || `IRM_WIN_PCT_MIN > `IRM_WIN_PCT_MAX)
         $error("input_reading_math: window span cannot be served");
   end

   typedef struct packed {
      logic [1:0]                   fvalid;
      logic [1:0][2:0][DATA_W-1:0]  filt;
      logic [1:0]                   primed;
      logic [1:0]                   out_valid;
      logic [1:0][2:0][DATA_W-1:0]  outv;
      logic [1:0][DATA_W-1:0]       lin;
      logic [1:0][DATA_W-1:0]       maxv;
      logic [1:0][DATA_W-1:0]       minv;
      logic [1:0]                   mm_have;
      logic [1:0][2:0][DATA_W-1:0]  loopv;
   } state_t;

   state_t state;
   state_t next_state;

   // Clamps the point count into its legal span.
   function automatic logic [6:0] clamp_pts(input logic [6:0] p);
      if (p < `IRM_FILT_PTS_MIN)
         return `IRM_FILT_PTS_MIN;
      else if (p > `IRM_FILT_PTS_MAX)
         return `IRM_FILT_PTS_MAX;
      return p;
   endfunction

   // Clamps the window percentage into its legal span.
   function automatic logic [3:0] clamp_win(input logic [3:0] w);
      if (w < `IRM_WIN_PCT_MIN)
         return `IRM_WIN_PCT_MIN;
      else if (w > `IRM_WIN_PCT_MAX)
         return `IRM_WIN_PCT_MAX;
      return w;
   endfunction

   // One smoothing step for a single quantity.
   function automatic logic [DATA_W-1:0] smooth(input logic [DATA_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [6:0] pts,
                                                input logic [DATA_W-1:0] lim,
                                                input logic primed);
      logic signed [DATA_W:0] diff;
      logic signed [DATA_W:0] mag;
      logic signed [DATA_W:0] step;
      diff = $signed({new_v[DATA_W-1], new_v}) - $signed({old_v[DATA_W-1], old_v});
      mag  = diff[DATA_W] ? -diff : diff;
      // Truncation toward zero leaves a residual of up to pts-1 counts on the old value's side of the reading.
      step = diff / $signed({{(DATA_W-6){1'b0}}, pts});
      if (!primed || mag > $signed({1'b0, lim}))
         return new_v;
      return DATA_W'($signed({old_v[DATA_W-1], old_v}) + step);
   endfunction

   // Signed fixed point product, result kept at data width.
   function automatic logic [DATA_W-1:0] fx_mul(input logic [DATA_W-1:0] a,
                                                input logic [DATA_W-1:0] b);
      logic signed [2*DATA_W-1:0] p;
      p = $signed(a) * $signed(b);
      // Results outside the data range wrap; the user must keep M and X in range.
      return p[FRAC_W +: DATA_W];
   endfunction

   // Two's complement sign inversion of a setpoint.
   function automatic logic [DATA_W-1:0] negate(input logic [DATA_W-1:0] v);
      return DATA_W'(-$signed(v));
   endfunction

   // Chooses the X operand among the three filtered quantities.
   function automatic logic [DATA_W-1:0] pick_x(input x_src_t sel,
                                                input logic [2:0][DATA_W-1:0] v);
      logic [DATA_W-1:0] r;
      unique case (sel)
         x_kelvin:  r = v[0];
         x_celsius: r = v[1];
         x_sensor:  r = v[2];
         default:   r = v[2];
      endcase
      return r;
   endfunction

   // Chooses the B operand; a setpoint enters with either sign.
   function automatic logic [DATA_W-1:0] pick_b(input b_src_t sel,
                                                input logic [DATA_W-1:0] user,
                                                input logic [DATA_W-1:0] sp_one,
                                                input logic [DATA_W-1:0] sp_two);
      logic [DATA_W-1:0] r;
      unique case (sel)
         b_number:    r = user;
         b_plus_one:  r = sp_one;
         b_minus_one: r = negate(sp_one);
         b_plus_two:  r = sp_two;
         b_minus_two: r = negate(sp_two);
         default:     r = user;
      endcase
      return r;
   endfunction

   // Chooses the quantity that the extremes follow.
   function automatic logic [DATA_W-1:0] pick_src(input mm_src_t sel,
                                                  input logic [2:0][DATA_W-1:0] v,
                                                  input logic [DATA_W-1:0] lin_v);
      logic [DATA_W-1:0] r;
      unique case (sel)
         src_kelvin:  r = v[0];
         src_celsius: r = v[1];
         src_sensor:  r = v[2];
         src_linear:  r = lin_v;
      endcase
      return r;
   endfunction

   // Both equation forms; the product is truncated to the data width.
   function automatic logic [DATA_W-1:0] linear_eq(input eq_form_t form,
                                                   input logic [DATA_W-1:0] m,
                                                   input logic [DATA_W-1:0] x_v,
                                                   input logic [DATA_W-1:0] b_v);
      if (form == eq_m_x_plus_b)
         return fx_mul(m, DATA_W'(x_v + b_v));
      return DATA_W'(fx_mul(m, x_v) + b_v);
   endfunction

   // Window limit as a share of full scale, each lane from its own range.
   function automatic logic [DATA_W-1:0] window_limit(input logic [DATA_W-1:0] full,
                                                      input logic [3:0] pct);
      logic [2*DATA_W-1:0] p;
      p = full * {{(DATA_W-4){1'b0}}, clamp_win(pct)};
      return DATA_W'(p / `IRM_PCT_DIV);
   endfunction

   // True when a candidate replaces a held extreme; an empty capture always takes it.
   function automatic logic beats(input logic have,
                                  input logic [DATA_W-1:0] cand,
                                  input logic [DATA_W-1:0] held,
                                  input logic want_max);
      if (!have)
         return 1'b1;
      if (want_max)
         return $signed(cand) > $signed(held);
      return $signed(cand) < $signed(held);
   endfunction

   always_comb
   begin
      logic [DATA_W-1:0]   x;
      logic [DATA_W-1:0]   b;
      logic [DATA_W-1:0]   lim;
      logic [DATA_W-1:0]   lin;
      logic [DATA_W-1:0]   src;
      logic [2:0][DATA_W-1:0] raw;
      logic [6:0]          pts;
      x    = '0;
      b    = '0;
      lim  = '0;
      lin  = '0;
      src  = '0;
      raw  = '0;
      pts  = '0;
      next_state = state;
      for (int i = 0; i < 2; i++)
      begin
         next_state.fvalid[i]    = 1'b0;
         next_state.out_valid[i] = 1'b0;
         raw[0] = i_kelvin[i];
         raw[1] = i_celsius[i];
         raw[2] = i_sensor[i];
         pts  = clamp_pts(i_filt_pts[i]);
         lim  = window_limit(i_full_scale[i], i_filt_win_pct[i]);
         // Disabling the filter forgets its value, so re-enabling restarts from a reading.
         if (!i_filt_en[i])
            next_state.primed[i] = 1'b0;
         if (i_valid[i])
         begin
            next_state.loopv[i] = raw;
            next_state.fvalid[i] = 1'b1;
            if (i_filt_en[i])
            begin
               for (int k = 0; k < 3; k++)
                  next_state.filt[i][k] = smooth(state.filt[i][k], raw[k], pts, lim,
                                                 state.primed[i]);
               next_state.primed[i] = 1'b1;
            end
            else
               next_state.filt[i] = raw;
         end

         // Second stage: linear equation on the filtered values.
         // x operand select
         x   = pick_x(i_x_src[i], state.filt[i]);
         b   = pick_b(i_b_src[i], i_offset[i], i_loop_one_setpoint, i_loop_two_setpoint);
         lin = linear_eq(i_eq_form[i], i_gain[i], x, b);
         src = pick_src(i_mm_src[i], state.filt[i], lin);

         if (state.fvalid[i])
         begin
            next_state.out_valid[i] = 1'b1;
            next_state.outv[i]      = state.filt[i];
            next_state.lin[i]       = lin;
            if (beats(state.mm_have[i], src, state.maxv[i], 1'b1))
               next_state.maxv[i] = src;
            if (beats(state.mm_have[i], src, state.minv[i], 1'b0))
               next_state.minv[i] = src;
            next_state.mm_have[i] = 1'b1;
         end

         // A clear on the same edge as a capture wins, so the extremes restart empty.
         // clear on change
         if (i_param_change[i] || i_math_reset[i])
         begin
            next_state.mm_have[i] = 1'b0;
            next_state.maxv[i]    = '0;
            next_state.minv[i]    = '0;
            next_state.primed[i]  = i_param_change[i] ? 1'b0 : next_state.primed[i];
         end
      end
   end

   // One register stage holds the whole state, so all lanes move together.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         state <= '0;
      else
         state <= next_state;
   end

   always_comb
   begin
      // Outputs are copies of state, so every data output comes from a flip-flop.
      o_valid    = state.out_valid;
      o_mm_valid = state.mm_have;
      o_linear   = state.lin;
      o_max      = state.maxv;
      o_min      = state.minv;
      for (int i = 0; i < 2; i++)
      begin
         o_kelvin[i]       = state.outv[i][0];
         o_celsius[i]      = state.outv[i][1];
         o_sensor[i]       = state.outv[i][2];
         o_loop_kelvin[i]  = state.loopv[i][0];
         o_loop_celsius[i] = state.loopv[i][1];
         o_loop_sensor[i]  = state.loopv[i][2];
      end
   end
endmodule

// file: testbench/input_reading_math_checker.sv
// Checker of the reading math block; it sees the block's ports only.
// Assumes it is bound into the block and shares its data width.
`timescale 1ns/1ps
module input_reading_math_checker
#(
   parameter int DATA_W = 32
)
(
   // Clock, reset and inputs
   input wire logic                   i_clock,
   input wire logic                   i_rst,
   input wire logic [1:0]             i_valid,
   input wire logic [1:0][DATA_W-1:0] i_sensor,
   input wire logic [1:0]             i_param_change,
   input wire logic [1:0]             i_math_reset,
   // Results
   input wire logic [1:0]             o_valid,
   input wire logic [1:0][DATA_W-1:0] o_loop_sensor,
   input wire logic [1:0][DATA_W-1:0] o_max,
   input wire logic [1:0][DATA_W-1:0] o_min,
   input wire logic [1:0]             o_mm_valid
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   wire [1:0] clr = i_math_reset | i_param_change;
   a_out_latency: assert property (i_valid[0] |-> ##2 o_valid[0])
      else $error("Result strobe missing.");
   a_no_spurious: assert property (o_valid[0] |-> $past(i_valid[0], 2))
      else $error("Result strobe without a reading.");
   a_lane_latency: assert property (i_valid[1] |-> ##2 o_valid[1])
      else $error("Second lane strobe missing.");
   a_loop_raw: assert property (i_valid[0] |=> o_loop_sensor[0] == $past(i_sensor[0]))
      else $error("Loop reading not raw.");
   a_mm_order: assert property (o_mm_valid[0] |-> $signed(o_max[0]) >= $signed(o_min[0]))
      else $error("Maximum below minimum.");
   a_mm_zero: assert property (!o_mm_valid[0] |-> o_max[0] == '0 && o_min[0] == '0)
      else $error("Extremes not cleared.");
   a_clear_drop: assert property (clr[0] |-> ##[1:2] !o_mm_valid[0])
      else $error("Clear did not drop capture.");
   a_capture_always: assert property (o_valid[0] && !$past(clr[0]) && !$past(clr[0], 2)
      |-> o_mm_valid[0]) else $error("Reading not captured.");
   a_extreme_mono: assert property (o_valid[0] && $past(o_mm_valid[0]) && o_mm_valid[0]
      |-> $signed(o_max[0]) >= $signed($past(o_max[0]))
      && $signed(o_min[0]) <= $signed($past(o_min[0]))) else $error("Extreme went back.");
endmodule
bind input_reading_math input_reading_math_checker #(.DATA_W(DATA_W)) chk (.i_clock(i_clock),
   .i_rst(i_rst), .i_valid(i_valid), .i_sensor(i_sensor), .i_param_change(i_param_change),
   .i_math_reset(i_math_reset), .o_valid(o_valid), .o_loop_sensor(o_loop_sensor),
   .o_max(o_max), .o_min(o_min), .o_mm_valid(o_mm_valid));

// file: testbench/reading_source.sv
// Model of the measurement path that hands readings to the block.
// Assumes one request cycle per reading and lane from the bench.
`timescale 1ns/1ps
module reading_source
(
   // Clock and requests
   input  wire logic             i_clock,
   input  wire logic [1:0]       i_req,
   input  wire logic [1:0][31:0] i_value,
   // Readings
   output logic [1:0]            o_valid,
   output logic [1:0][31:0]      o_kelvin,
   output logic [1:0][31:0]      o_celsius,
   output logic [1:0][31:0]      o_sensor
);
   initial {o_valid, o_kelvin, o_celsius, o_sensor} = '0;
   // Independent lanes.
   // Between strobes the lines toggle, so a late sample shows up as a wrong value.
   always @(posedge i_clock)
   begin
      o_valid <= i_req;
      for (int i = 0; i < 2; i++)
      begin
         o_kelvin[i] <= i_req[i] ? i_value[i] : ~o_kelvin[i];
         o_celsius[i] <= i_req[i] ? i_value[i] + 32'h00100000 : ~o_celsius[i];
         o_sensor[i] <= i_req[i] ? i_value[i] + 32'h00030000 : ~o_sensor[i];
      end
   end
endmodule

// file: testbench/input_reading_math_bench.sv
// Self-checking bench of the reading math block with seeded random readings.
// Assumes the reading source model and the bound checker are compiled with it.
`timescale 1ns/1ps
module input_reading_math_bench;
   import input_reading_math_pkg::*;
   localparam logic [31:0] OC = 32'h00100000;
   localparam logic [31:0] OS = 32'h00030000;
   logic clock = 1'b0, rst = 1'b1;
   logic [1:0] req = '0, fen = '0, pchg = '0, mrst = '0, vld, ov, omv;
   logic [1:0][31:0] val = '0, fs = {2{32'h00640000}}, gain = {2{32'h00020000}}, ofs = '0;
   logic [1:0][31:0] kel, cel, sen, ok, oc, os, ol, omx, omn, olk, olc;
   logic [1:0][6:0] pts = {2{7'h08}};
   logic [1:0][3:0] win = {2{4'h1}};
   logic [31:0] set_one = '0, set_two = '0;
   mm_src_t mms [2] = '{src_sensor, src_sensor};
   x_src_t xs [2] = '{x_sensor, x_sensor};
   b_src_t bs [2] = '{b_number, b_number};
   eq_form_t eqf [2] = '{eq_mx_plus_b, eq_mx_plus_b};
   logic signed [31:0] f = '0, mx, mn;
   logic prim = 1'b0, have = 1'b0;
   int fails = 0, n_tests = 0, ep = 8, lim = 65536;
   always #25 clock = ~clock;
   reading_source src (.i_clock(clock), .i_req(req), .i_value(val), .o_valid(vld),
      .o_kelvin(kel), .o_celsius(cel), .o_sensor(sen));
   input_reading_math dut (.i_clock(clock), .i_rst(rst), .i_valid(vld), .i_kelvin(kel),
      .i_celsius(cel), .i_sensor(sen), .i_full_scale(fs), .i_loop_one_setpoint(set_one),
      .i_loop_two_setpoint(set_two), .i_mm_src(mms), .i_x_src(xs), .i_b_src(bs),
      .i_eq_form(eqf), .i_gain(gain), .i_offset(ofs), .i_filt_en(fen), .i_filt_pts(pts),
      .i_filt_win_pct(win), .i_param_change(pchg), .i_math_reset(mrst), .o_valid(ov),
      .o_kelvin(ok), .o_celsius(oc), .o_sensor(os), .o_linear(ol), .o_max(omx),
      .o_min(omn), .o_mm_valid(omv), .o_loop_kelvin(olk), .o_loop_celsius(olc),
      .o_loop_sensor());
   function automatic logic [31:0] rnd(logic [31:0] m);
      return ($urandom & m) - (m >> 1);
   endfunction
   function automatic logic [31:0] lin(logic [31:0] k);
      logic [31:0] x, b;
      x = (xs[0] == x_kelvin) ? k : (xs[0] == x_celsius) ? k + OC : k + OS;
      b = (bs[0] == b_number) ? ofs[0] : (bs[0] == b_plus_one) ? set_one
        : (bs[0] == b_minus_one) ? -set_one : (bs[0] == b_plus_two) ? set_two : -set_two;
      return (eqf[0] == eq_mx_plus_b) ? (x << 1) + b : (x + b) << 1;
   endfunction
   function automatic logic [31:0] filt(logic [31:0] v);
      logic signed [31:0] d;
      d = $signed(v) - f;
      if (!fen[0] || !prim || d > lim || d < -lim)
         return v;
      return f + d / ep;
   endfunction
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(logic [31:0] g, logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wait_out(int l);
      for (int n = 0; n < 8 && ov[l] !== 1'b1; n++)
      begin
         @(posedge clock);
         #1;
      end
      if (ov[l] !== 1'b1)
      begin
         fails++;
         end_of_test();
      end
   endtask
   task automatic cfg(mm_src_t m, x_src_t x, b_src_t b, eq_form_t e, logic en, int p, int w);
      @(posedge clock);
      mms[0] <= m;
      xs[0] <= x;
      bs[0] <= b;
      eqf[0] <= e;
      fen[0] <= en;
      pts[0] <= 7'(p);
      win[0] <= 4'(w);
      pchg[0] <= 1'b1;
      @(posedge clock);
      pchg[0] <= 1'b0;
      have = 1'b0;
      prim = 1'b0;
      ep = (p < 2) ? 2 : (p > 64) ? 64 : p;
      lim = 32'h00640000 * ((w < 1) ? 1 : (w > 10) ? 10 : w) / 100;
      repeat (3) @(posedge clock);
      check({31'h0, omv[0]}, 32'h0);
   endtask
   task automatic rd(logic [31:0] v);
      logic [31:0] k, s;
      k = filt(v);
      s = (mms[0] == src_kelvin) ? k : (mms[0] == src_celsius) ? k + OC
        : (mms[0] == src_sensor) ? k + OS : lin(k);
      mx = (!have || $signed(s) > mx) ? s : mx;
      mn = (!have || $signed(s) < mn) ? s : mn;
      have = 1'b1;
      f = k;
      prim = fen[0];
      @(posedge clock);
      req[0] <= 1'b1;
      val[0] <= v;
      @(posedge clock);
      req[0] <= 1'b0;
      wait_out(0);
      check(ok[0], k);
      check(oc[0], k + OC);
      check(os[0], k + OS);
      check(ol[0], lin(k));
      check(omx[0], mx);
      check(omn[0], mn);
      check(olk[0], v);
      check(olc[0], v + OC);
   endtask
   initial
   begin
      void'($urandom(40));
      set_one <= rnd(32'h003FFFFF);
      set_two <= rnd(32'h003FFFFF);
      ofs[0] <= rnd(32'h003FFFFF);
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      req[1] <= 1'b1;
      val[1] <= 32'h00050000;
      @(posedge clock);
      req[1] <= 1'b0;
      wait_out(1);
      check(ok[1], 32'h00050000);
      for (int i = 0; i < 30; i++)
      begin
         cfg(src_linear, x_src_t'(i % 3), b_src_t'(i / 6), eq_form_t'((i / 3) % 2), 0, 8, 1);
         repeat (2) rd(rnd(32'h001FFFFF));
      end
      for (int m = 0; m < 4; m++)
      begin
         cfg(mm_src_t'(m), x_sensor, b_number, eq_mx_plus_b, 0, 8, 1);
         repeat (6) rd(rnd(32'h001FFFFF));
      end
      cfg(src_kelvin, x_kelvin, b_minus_two, eq_m_x_plus_b, 1, 1, 0);
      repeat (10) rd(f + rnd(32'h0000FFFF));
      rd(f + lim);
      rd(f + 32'h00200000);
      cfg(src_kelvin, x_celsius, b_plus_one, eq_mx_plus_b, 1, 100, 15);
      repeat (12) rd(f + rnd(32'h0007FFFF));
      rd(f - lim - 1);
      @(posedge clock);
      mrst[0] <= 1'b1;
      @(posedge clock);
      mrst[0] <= 1'b0;
      repeat (3) @(posedge clock);
      check({31'h0, omv[0]}, 32'h0);
      check({31'h0, omv[1]}, 32'h1);
      have = 1'b0;
      rd(f + 32'h00001000);
      end_of_test();
   end
endmodule
